// File: nvcl_loader.sv
/*
 * Non-volatile configuration store and its loader: startup copy, preset
 * and user-setting copies, page programming and interface configuration.
 * Assumes an AXI4-Lite master with one write and one read outstanding and
 * strap pins synchronous to aclk.
 */
`timescale 1ns/1ps
// Overview of operation
// R1: after reset the reset-settings area is copied into registers unasked.
// R2: preset command copies the selected read-only preset into the registers.
// R3: user command copies settings from the free user section into registers.
// R4: the store holds 8192 bytes in 64-byte pages.
// R5: programming writes exactly one 64-byte page per operation.
// R6: page 0 low half read-only; reset and user areas writable.
// R7: key section is write-only; preset section is read-only.
// R8: production bytes hold part identifier, version at 3, factory bytes.
// R9: configuration bytes sit at fixed store addresses from 0x20 onward.
// R10: pin address is 10101 followed by the two strap pins.
// R11: interface byte bit 4 chooses pin or stored bus address.
// R12: interface byte bit 7 selects high speed plus; default set.
// R13: bit 4 clear uses strap pins, bit 4 set uses stored byte.
// R14: bit 3 clear enables boundary scan, set disables it.
// R15: bits 2:0 select host interface; 1xx means pin strapping.
// R16: secure-module bus address always comes from the stored byte.
// R17: host accesses are held off until the startup copy ends.
module nvcl_loader #(
   parameter logic [23:0] PART_ID = 24'h00A5C3,
   parameter logic [7:0] SILICON_VER = 8'h1E
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic iface_strap_low,
   input wire logic iface_strap_high,
   input wire logic [1:0] host_strap,
   output nvcl_pkg::nvcl_cfg_t cfg_out
);
   import nvcl_pkg::*;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   // PART_ID and SILICON_VER values are arbitrary.
   logic [7:0] nv_mem [NV_BYTES]; // see R4
   logic [7:0] page_buf [PAGE_BYTES];
   logic [7:0] dev_reg [REG_N];
   nvcl_st_t st_r;
   nvcl_st_t st_nxt;
   logic mem_we;
   logic buf_we;
   logic reg_we;
   logic [6:0] reg_wa;
   logic [7:0] reg_wd;
   logic [7:0] copy_byte;
   logic [7:0] iface_byte;
   logic [7:0] addr_byte;
   logic [7:0] sam_byte;
   logic pre_go;
   logic usr_go;
   logic prg_go;

   // Unprogrammed pages read as the blank factory image, so the store
   // needs no reset and the interface byte still shows its default.
   function automatic logic [7:0] nv_rd(input logic [12:0] a,
                                        input logic [127:0] pv,
                                        input logic [7:0] m);
      logic [7:0] v;
      v = pv[a[12:6]] ? m : ((a == IFACE_ADDR) ? IFACE_ERASED : 8'h00);
      if (a < VERSION_ADDR) begin // see R8
         v = PART_ID[8*(2-a[1:0]) +: 8];
      end else if (a == VERSION_ADDR) begin
         v = SILICON_VER;
      end
      return v;
   endfunction

   assign copy_byte = nv_rd(st_r.src, st_r.pvalid, nv_mem[st_r.src]);
   assign iface_byte = nv_rd(IFACE_ADDR, st_r.pvalid, nv_mem[IFACE_ADDR]);
   assign addr_byte = nv_rd(BUS_ADDR_ADDR, st_r.pvalid,
                            nv_mem[BUS_ADDR_ADDR]); // see R9
   assign sam_byte = nv_rd(SAM_ADDR_ADDR, st_r.pvalid,
                           nv_mem[SAM_ADDR_ADDR]);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic [1:0] rr;
      logic [1:0] wr;
      logic [11:0] wa;
      logic [12:0] na;
      logic go_busy;
      rd = 32'h0000_0000;
      rr = RESP_OKAY;
      wr = RESP_OKAY;
      wa = st_r.awaddr;
      na = st_r.nv_addr;
      go_busy = 1'b0;
      st_nxt = st_r;
      mem_we = 1'b0;
      buf_we = 1'b0;
      reg_we = 1'b0;
      reg_wa = st_r.dst;
      reg_wd = copy_byte;
      pre_go = 1'b0;
      usr_go = 1'b0;
      prg_go = 1'b0;

      case (st_r.state)
         S_COPY: begin
            reg_we = 1'b1; // see R1 R2 R3
            st_nxt.src = st_r.src + 13'h0001;
            st_nxt.dst = st_r.dst + 7'h01;
            st_nxt.cnt = st_r.cnt - 8'h01;
            if (st_r.cnt == 8'h01) begin
               if (st_r.seg2) begin
                  st_nxt.seg2 = 1'b0;
                  st_nxt.src = PRESET_LO + PRESET_RX_OFS
                     + {st_r.preset_sel, 5'h00};
                  st_nxt.dst = PRESET_RX_DST;
                  st_nxt.cnt = PRESET_RX_LEN;
               end else begin
                  st_nxt.state = S_IDLE;
                  st_nxt.boot_done = 1'b1;
               end
            end
         end
         S_PROG: begin
            // Page 0 low half keeps its factory content.
            mem_we = !(st_r.src[12:6] == 7'h00
                       && st_r.src[5:0] < PROD_RO_END); // see R6
            st_nxt.src = st_r.src + 13'h0001;
            st_nxt.cnt = st_r.cnt - 8'h01;
            if (st_r.cnt == 8'h01) begin
               st_nxt.state = S_IDLE;
               st_nxt.pvalid[st_r.src[12:6]] = 1'b1;
            end
         end
         S_IDLE: begin
         end
         default: st_nxt.state = S_IDLE;
      endcase

      // Write channel: address and data taken in either order.
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
         wa = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         case (wa)
            OFS_CTRL: begin
               if (st_r.state != S_IDLE || st_r.wdata[2:0] == 3'h0) begin
                  wr = RESP_SLVERR;
               end else if (st_r.wdata[CTRL_PRESET]) begin
                  pre_go = 1'b1;
               end else if (st_r.wdata[CTRL_USER]) begin
                  usr_go = 1'b1;
               end else begin
                  prg_go = 1'b1;
               end
            end
            OFS_PRESET: st_nxt.preset_sel = st_r.wdata[4:0];
            OFS_USRC: st_nxt.user_src = st_r.wdata[12:0];
            OFS_UDST: st_nxt.user_dst = st_r.wdata[6:0];
            OFS_ULEN: st_nxt.user_len = st_r.wdata[7:0];
            OFS_STATUS: begin
               if (st_r.wdata[ST_ERR]) begin
                  st_nxt.err = 1'b0;
               end
            end
            OFS_NVADDR: st_nxt.nv_addr = st_r.wdata[12:0];
            OFS_NVDATA: buf_we = 1'b1;
            OFS_CFG: wr = RESP_SLVERR;
            default: begin
               if (wa[11:9] == 3'h1 && st_r.state == S_IDLE) begin
                  reg_we = 1'b1;
                  reg_wa = wa[8:2];
                  reg_wd = st_r.wdata[7:0];
               end else begin
                  wr = RESP_SLVERR;
               end
            end
         endcase
         st_nxt.bresp = wr;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // Command launch.
      if (pre_go) begin
         st_nxt.state = S_COPY; // see R2
         st_nxt.seg2 = 1'b1;
         st_nxt.src = PRESET_LO + {st_r.preset_sel, 5'h00};
         st_nxt.dst = PRESET_TX_DST;
         st_nxt.cnt = PRESET_TX_LEN;
      end
      if (usr_go) begin
         // Copies stay inside the free section and the register file.
         if (st_r.user_len == 8'h00 || st_r.user_src < USER_LO
             || {1'b0, st_r.user_src} + {6'h00, st_r.user_len} > {1'b0, KEY_LO}
             || {2'h0, st_r.user_dst} + {1'b0, st_r.user_len} > 9'h080) begin
            go_busy = 1'b1;
         end else begin
            st_nxt.state = S_COPY; // see R3
            st_nxt.src = st_r.user_src;
            st_nxt.dst = st_r.user_dst;
            st_nxt.cnt = st_r.user_len;
         end
      end
      if (prg_go) begin
         if (st_r.nv_addr[12:6] >= PRESET_PAGE) begin // see R7
            go_busy = 1'b1;
         end else begin
            st_nxt.state = S_PROG; // see R5
            st_nxt.src = {st_r.nv_addr[12:6], 6'h00};
            st_nxt.cnt = 8'h40;
         end
      end
      if (go_busy) begin
         st_nxt.bresp = RESP_SLVERR;
      end

      // Read channel.
      if (s_axi_arvalid && st_r.arready) begin
         case (s_axi_araddr)
            OFS_PRESET: rd = {27'h0, st_r.preset_sel};
            OFS_USRC: rd = {19'h0, st_r.user_src};
            OFS_UDST: rd = {25'h0, st_r.user_dst};
            OFS_ULEN: rd = {24'h0, st_r.user_len};
            OFS_STATUS: rd = {29'h0, st_r.err, st_r.boot_done,
                              st_r.state != S_IDLE};
            OFS_NVADDR: rd = {19'h0, st_r.nv_addr};
            OFS_NVDATA: begin
               if (na[12:6] >= KEY_PAGE && na[12:6] < PRESET_PAGE) begin
                  rr = RESP_SLVERR; // see R7
               end else begin
                  rd = {24'h0, nv_rd(na, st_r.pvalid, nv_mem[na])};
               end
            end
            OFS_CFG: rd = {6'h00, st_r.cfg, iface_byte};
            default: begin
               if (s_axi_araddr[11:9] == 3'h1) begin
                  rd = {24'h0, dev_reg[s_axi_araddr[8:2]]};
               end else begin
                  rr = RESP_SLVERR;
               end
            end
         endcase
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd;
         st_nxt.rresp = rr;
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // Error flag: a new fault wins over a clear in the same cycle.
      if (wr == RESP_SLVERR || go_busy || rr == RESP_SLVERR) begin
         st_nxt.err = 1'b1;
      end

      st_nxt.awready = st_nxt.boot_done && !st_nxt.aw_got; // see R17
      st_nxt.wready = st_nxt.boot_done && !st_nxt.w_got;
      st_nxt.arready = st_nxt.boot_done && !st_nxt.rvalid;

      // Interface configuration from the stored bytes.
      st_nxt.cfg.bus_addr = iface_byte[IF_ADDR_SRC_BIT] // see R11 R13
         ? addr_byte[6:0]
         : {PIN_ADDR_HI, iface_strap_high, iface_strap_low}; // see R10
      st_nxt.cfg.sam_addr = sam_byte[6:0]; // see R16
      st_nxt.cfg.speed_plus = iface_byte[IF_SPEED_BIT]; // see R12
      st_nxt.cfg.scan_enable = !iface_byte[IF_SCAN_BIT]; // see R14
      st_nxt.cfg.host_sel = iface_byte[IF_HOST_PIN_BIT] // see R15
         ? host_strap : iface_byte[1:0];
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.state <= S_COPY;
         st_r.src <= BOOT_SRC;
         st_r.cnt <= BOOT_LEN;
         st_r.cfg.speed_plus <= 1'b1;
         st_r.cfg.scan_enable <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // The store array is not reset, but reset clears pvalid, so every page reads blank.
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         nv_mem[st_r.src] <= page_buf[st_r.src[5:0]];
      end
      if (buf_we) begin
         page_buf[st_r.nv_addr[5:0]] <= st_r.wdata[7:0];
      end
      if (reg_we) begin
         dev_reg[reg_wa] <= reg_wd;
      end
   end

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign cfg_out = st_r.cfg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [8:0] boot_cyc;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_cyc <= 9'h000;
      end else if (!st_r.boot_done) begin
         boot_cyc <= boot_cyc + 9'h001;
      end
   end

   AST_BOOT_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
      $rose(st_r.boot_done) |-> boot_cyc == 9'h080)
      else $error("startup copy length wrong");
   AST_HOLD_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // see R17
      !st_r.boot_done |-> !s_axi_awready && !s_axi_arready && !s_axi_wready)
      else $error("bus accepted before startup copy");
   AST_PRESET: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
      pre_go |=> st_r.state == S_COPY && st_r.cnt == 8'h10 ##16
      st_r.dst == PRESET_RX_DST && st_r.cnt == 8'h08)
      else $error("preset copy sequence wrong");
   AST_PROG_PAGE: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
      prg_go && st_r.nv_addr[12:6] < PRESET_PAGE |=>
      (st_r.state == S_PROG)[*8] ##57 st_r.state == S_IDLE)
      else $error("page program length wrong");
   AST_PIN_ADDR: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
      !iface_byte[IF_ADDR_SRC_BIT] |=> cfg_out.bus_addr ==
      {PIN_ADDR_HI, $past(iface_strap_high), $past(iface_strap_low)})
      else $error("pin bus address wrong");
   AST_STORED_ADDR: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
      iface_byte[IF_ADDR_SRC_BIT] |=> cfg_out.bus_addr == $past(addr_byte[6:0]))
      else $error("stored bus address wrong");
   AST_SPEED: assert property (@(posedge aclk) disable iff (!aresetn) // see R12
      ##1 cfg_out.speed_plus == $past(iface_byte[IF_SPEED_BIT]))
      else $error("speed mode wrong");
   AST_SCAN: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
      $changed(iface_byte[IF_SCAN_BIT]) |=>
      cfg_out.scan_enable != $past(iface_byte[IF_SCAN_BIT]))
      else $error("scan enable wrong");
   AST_HOST: assert property (@(posedge aclk) disable iff (!aresetn) // see R15
      iface_byte[IF_HOST_PIN_BIT] |=> cfg_out.host_sel == $past(host_strap))
      else $error("strapped host select wrong");
   AST_SAM: assert property (@(posedge aclk) disable iff (!aresetn) // see R16
      ##1 cfg_out.sam_addr == $past(sam_byte[6:0]))
      else $error("secure module address wrong");
   AST_KEY_READ: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_NVDATA
      && st_r.nv_addr[12:6] >= KEY_PAGE && st_r.nv_addr[12:6] < PRESET_PAGE
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("key section readable");
endmodule

// File: nvcl_pkg.sv
/*
 * Constants, field layouts and types for the configuration store loader.
 * Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
 */
package nvcl_pkg;
   // ------------------------------------------------------------------
   // Store map
   // ------------------------------------------------------------------
   localparam int NV_BYTES = 8192;
   localparam int PAGE_BYTES = 64;
   localparam int PAGES = 128;
   localparam int REG_N = 128;
   localparam logic [12:0] BOOT_SRC = 13'h0040;
   localparam logic [7:0] BOOT_LEN = 8'h80;
   localparam logic [12:0] USER_LO = 13'h00C0;
   localparam logic [12:0] USER_HI = 13'h17FF;
   localparam logic [12:0] KEY_LO = 13'h1800;
   localparam logic [12:0] PRESET_LO = 13'h1C00;
   localparam logic [6:0] KEY_PAGE = 7'h60;
   localparam logic [6:0] PRESET_PAGE = 7'h70;
   localparam logic [5:0] PROD_RO_END = 6'h20;
   localparam logic [12:0] VERSION_ADDR = 13'h0003;
   localparam logic [12:0] BUS_ADDR_ADDR = 13'h0020;
   localparam logic [12:0] IFACE_ADDR = 13'h0021;
   localparam logic [12:0] SAM_ADDR_ADDR = 13'h0022;
   localparam logic [7:0] IFACE_ERASED = 8'h80;
   localparam logic [4:0] PIN_ADDR_HI = 5'h15;
   localparam int IF_SPEED_BIT = 7;
   localparam int IF_ADDR_SRC_BIT = 4;
   localparam int IF_SCAN_BIT = 3;
   localparam int IF_HOST_PIN_BIT = 2;
   // ------------------------------------------------------------------
   // Protocol preset slots: 16 transmit bytes then 8 receive bytes
   // ------------------------------------------------------------------
   localparam int PRESET_SLOT_SH = 5;
   localparam logic [7:0] PRESET_TX_LEN = 8'h10;
   localparam logic [7:0] PRESET_RX_LEN = 8'h08;
   localparam logic [12:0] PRESET_RX_OFS = 13'h0010;
   localparam logic [6:0] PRESET_TX_DST = 7'h28;
   localparam logic [6:0] PRESET_RX_DST = 7'h58;
   // ------------------------------------------------------------------
   // Register bus map
   // ------------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_PRESET = 12'h004;
   localparam logic [11:0] OFS_USRC = 12'h008;
   localparam logic [11:0] OFS_UDST = 12'h00C;
   localparam logic [11:0] OFS_ULEN = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   localparam logic [11:0] OFS_NVADDR = 12'h018;
   localparam logic [11:0] OFS_NVDATA = 12'h01C;
   localparam logic [11:0] OFS_CFG = 12'h020;
   localparam logic [11:0] OFS_REGWIN = 12'h200;
   localparam int CTRL_PRESET = 0;
   localparam int CTRL_USER = 1;
   localparam int CTRL_PROG = 2;
   localparam int ST_ERR = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {S_COPY, S_IDLE, S_PROG} nvcl_state_t;

   typedef struct packed {
      logic [6:0] bus_addr;
      logic [6:0] sam_addr;
      logic speed_plus;
      logic scan_enable;
      logic [1:0] host_sel;
   } nvcl_cfg_t;

   typedef struct packed {
      nvcl_state_t state;
      logic boot_done;
      logic seg2;
      logic err;
      logic [12:0] src;
      logic [6:0] dst;
      logic [7:0] cnt;
      logic [127:0] pvalid;
      logic [4:0] preset_sel;
      logic [12:0] user_src;
      logic [6:0] user_dst;
      logic [7:0] user_len;
      logic [12:0] nv_addr;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      nvcl_cfg_t cfg;
   } nvcl_st_t;
endpackage

// File: nvcl_host_model.sv
/*
 * Host model: AXI4-Lite master that issues register and load requests.
 * Assumes the bench supplies aclk; hang rises if an answer never comes.
 */
`timescale 1ns/1ps
module nvcl_host_model (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   output logic hang
);
   // ----------
   // Bus cycles
   // ----------
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready, hang} = '0;
   end
   // The bound covers the startup hold-off of some 130 cycles.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      r = 2'h3;
      @(posedge aclk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 400; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 400) hang <= 1'b1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      {d, r} = '1;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 400; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            {d, r} = {rdata, rresp};
            rready <= 1'b0;
            break;
         end
      end
      if (n == 400) hang <= 1'b1;
   endtask
endmodule

// File: nvcl_loader_tb.sv
/*
 * Self-checking bench for the configuration store loader.
 * Assumes the host model drives the bus; straps are random levels.
 */
`timescale 1ns/1ps
module nvcl_loader_tb;
   import nvcl_pkg::*;
   // -----------------
   // Signals and tasks
   // -----------------
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, hang, st_lo, st_hi;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, st_host;
   nvcl_cfg_t cfg_out;
   logic [7:0] mem [0:8191];
   int err_total, n_checks, cyc;
   localparam logic [7:0] IFB [5] = '{8'h00, 8'h99, 8'h02, 8'h0B, 8'h96};
   nvcl_loader i_nvcl_loader (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid),
      .s_axi_awready(awready),
      .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid),
      .s_axi_wready(wready),
      .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid),
      .s_axi_bready(bready),
      .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid),
      .s_axi_arready(arready),
      .s_axi_rdata(rdata),
      .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .iface_strap_low(st_lo),
      .iface_strap_high(st_hi),
      .host_strap(st_host),
      .cfg_out(cfg_out)
   );
   nvcl_host_model i_nvcl_host_model (.aclk(aclk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .hang(hang));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   always @(posedge hang) begin
      err_total++;
      summarize();
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] er);
      logic [1:0] r;
      i_nvcl_host_model.wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask
   // Error answers carry no defined data, except a refused store read.
   task automatic rreg(input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      logic [1:0] r;
      logic [31:0] d;
      i_nvcl_host_model.rd(a, d, r);
      chk("rresp", {30'h0, r}, {30'h0, er});
      if (er === RESP_OKAY || a === OFS_NVDATA) chk("rdata", d, e);
   endtask
   task automatic wait_idle();
      logic [1:0] r;
      logic [31:0] d;
      int n;
      d = 32'h1;
      for (n = 0; n < 100 && d[0] !== 1'b0; n++)
         i_nvcl_host_model.rd(OFS_STATUS, d, r);
      if (d[0] !== 1'b0) begin
         err_total++;
         summarize();
      end
   endtask
   // A whole page per operation; the address is set again for each byte.
   task automatic prog(input logic [6:0] pg);
      logic [12:0] a;
      for (int i = 0; i < 64; i++) begin
         a = {pg, i[5:0]};
         wreg(OFS_NVADDR, {19'h0, a}, RESP_OKAY);
         wreg(OFS_NVDATA, {24'h0, a < 13'h20 ? ~mem[a] : mem[a]}, RESP_OKAY);
      end
      wreg(OFS_CTRL, 32'h4, RESP_OKAY);
      wait_idle();
   endtask
   function automatic logic [11:0] wa(input logic [6:0] i);
      return OFS_REGWIN + {3'h0, i, 2'h0};
   endfunction
   function automatic nvcl_cfg_t ecfg();
      nvcl_cfg_t c;
      logic [7:0] f;
      f = mem[IFACE_ADDR];
      c.bus_addr = f[IF_ADDR_SRC_BIT] ? mem[BUS_ADDR_ADDR][6:0]
                                      : {PIN_ADDR_HI, st_hi, st_lo};
      c.sam_addr = mem[SAM_ADDR_ADDR][6:0];
      c.speed_plus = f[IF_SPEED_BIT];
      c.scan_enable = ~f[IF_SCAN_BIT];
      c.host_sel = f[IF_HOST_PIN_BIT] ? st_host : f[1:0];
      return c;
   endfunction
   function automatic logic [31:0] epre(input int i);
      return (i >= 8'h28 && i < 8'h38) || (i >= 8'h58 && i < 8'h60) ? 0 : 8'hA5;
   endfunction
   // --------
   // Sequence
   // --------
   initial begin
      int i, k, t0;
      {err_total, n_checks, cyc} = '0;
      aresetn = 1'b0;
      for (i = 0; i < 8192; i++) mem[i] = 8'h00;
      mem[IFACE_ADDR] = IFACE_ERASED;
      mem[VERSION_ADDR] = 8'h1E;
      i = $urandom(32'h4e2f);
      {st_hi, st_lo, st_host} = 4'(i);
      repeat (10) @(posedge aclk);
      chk("cfg_rst", {14'h0, cfg_out}, 32'hC);
      aresetn <= 1'b1;
      t0 = cyc;
      rreg(OFS_STATUS, 32'h2, RESP_OKAY);
      chk("hold_off", {31'h0, cyc - t0 >= 128}, 32'h1);
      // Factory-private bytes are left unchecked on purpose.
      for (k = 0; k < 5; k++) begin
         for (i = 32; i < 64; i++) mem[i] = 8'($urandom);
         mem[IFACE_ADDR] = IFB[k];
         @(posedge aclk);
         {st_hi, st_lo, st_host} <= 4'($urandom);
         prog(7'h0);
         chk("cfg", {14'h0, cfg_out}, {14'h0, ecfg()});
         rreg(OFS_CFG, {6'h0, ecfg(), mem[IFACE_ADDR]}, RESP_OKAY);
         wreg(OFS_NVADDR, {19'h0, VERSION_ADDR}, RESP_OKAY);
         rreg(OFS_NVDATA, {24'h0, mem[VERSION_ADDR]}, RESP_OKAY);
      end
      for (i = 0; i < 128; i++) wreg(wa(i), 32'hA5, RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Programmed pages do not outlast a reset; the store reads blank.
      for (i = 0; i < 8192; i++) mem[i] = 8'h00;
      mem[IFACE_ADDR] = IFACE_ERASED;
      rreg(OFS_STATUS, 32'h2, RESP_OKAY);
      for (i = 0; i < 128; i++)
         rreg(wa(i), {24'h0, mem[64 + i]}, RESP_OKAY);
      chk("cfg", {14'h0, cfg_out}, {14'h0, ecfg()});
      for (k = 1; k < 4; k++) begin
         for (i = 0; i < 64; i++) mem[k * 64 + i] = 8'($urandom);
         prog(k[6:0]);
      end
      for (i = 0; i < 128; i++) wreg(wa(i), 32'hA5, RESP_OKAY);
      for (i = 0; i < 128; i++) rreg(wa(i), 32'hA5, RESP_OKAY);
      wreg(OFS_PRESET, 32'($urandom) & 32'h1F, RESP_OKAY);
      wreg(OFS_CTRL, 32'h1, RESP_OKAY);
      wait_idle();
      for (i = 0; i < 128; i++) rreg(wa(i), epre(i), RESP_OKAY);
      wreg(OFS_USRC, 32'd199, RESP_OKAY);
      wreg(OFS_UDST, 32'd100, RESP_OKAY);
      wreg(OFS_ULEN, 32'd28, RESP_OKAY);
      wreg(OFS_CTRL, 32'h2, RESP_OKAY);
      wait_idle();
      for (i = 100; i < 128; i++) rreg(wa(i), mem[99 + i], RESP_OKAY);
      wreg(OFS_USRC, 32'd100, RESP_OKAY);
      wreg(OFS_CTRL, 32'h2, RESP_SLVERR);
      rreg(OFS_STATUS, 32'h6, RESP_OKAY);
      wreg(OFS_STATUS, 32'h4, RESP_OKAY);
      wreg(OFS_NVADDR, {19'h0, KEY_LO}, RESP_OKAY);
      rreg(OFS_NVDATA, 32'h0, RESP_SLVERR);
      wreg(OFS_NVADDR, {19'h0, PRESET_LO}, RESP_OKAY);
      wreg(OFS_CTRL, 32'h4, RESP_SLVERR);
      rreg(OFS_NVDATA, 32'h0, RESP_OKAY);
      rreg(12'h100, 32'h0, RESP_SLVERR);
      wreg(OFS_CFG, 32'h0, RESP_SLVERR);
      wreg(OFS_STATUS, 32'h4, RESP_OKAY);
      rreg(OFS_STATUS, 32'h2, RESP_OKAY);
      summarize();
   end
endmodule
